// ==== hdl/hbl_host_port.sv ====
// Parallel host port front end: strap decode, multiplexed address latch, doubleword assembly
//
// Behaviour
// - Strap picks multiplexed address/data or separate address with index accesses.
// - Host data width strap selects sixteen or eight bits; internal words stay 32.
// - Narrow writes assemble into a doubleword; narrow reads are counted per doubleword.
// - Strap picks separate read/write strobes or enable plus direction.
// - Select, read/direction, write/enable and both latch strobes have own polarity.
// - Byte order follows latched endian bit when multiplexed, else configuration input.
// - Latched FIFO-direct bit sends writes and reads to the process-memory FIFOs.
// - Multiplexed mode has single phase on sixteen pins or dual phase on eight.
// - Single phase latches address, FIFO and endian bits at low strobe trailing edge.
// - Eight-bit single phase never drives upper pins.
// - Optional select qualification: capture only if select active during the strobe.
// - Latched address holds until reset or a new capture.
// - Dual phase: low byte at low strobe end, rest at high strobe end, any order.
// - Dual phase upper pins unused at eight bits, data only at sixteen bits.
// - Dual phase qualification needs select active during each strobe.
// - Eight-bit: address bit n on pin n, byte range to 3FFh.
// - Sixteen-bit: address bit 1 on pin 0 upward, word range to 1FFh.
// - Every latched address is presented inside as a byte address.
// - Endian bit sits one pin above the top address bit.
// - FIFO-direct bit sits two pins above the top address bit.
// - Endian bit zero means little endian, one means big endian.
`timescale 1ns/1ps
module hbl_host_port
	import hbl_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// Configuration straps
	input  wire logic              cfg_mux_mode,
	input  wire logic              cfg_width16,
	input  wire logic              cfg_enable_dir,
	input  wire logic              cfg_dual_phase,
	input  wire logic              cfg_cs_qualify,
	input  wire logic              cfg_endian_big,
	input  wire logic              pol_cs,
	input  wire logic              pol_rd,
	input  wire logic              pol_wr,
	input  wire logic              pol_latch_low,
	input  wire logic              pol_latch_high,
	// Host pins
	input  wire logic              cs_pin,
	input  wire logic              rd_pin,
	input  wire logic              wr_pin,
	input  wire logic              latch_low_strobe,
	input  wire logic              latch_high_strobe,
	input  wire logic [AD_W-1:0]   ad_in,
	output logic      [AD_W-1:0]   ad_out,
	output logic      [AD_W-1:0]   ad_oe_n,
	// Index address for separate address mode
	input  wire logic [ADDR_W-1:0] index_addr,
	// Internal side
	output logic      [ADDR_W-1:0] host_addr,
	output logic                   host_big_endian,
	output logic                   host_fifo_direct,
	output logic                   dw_wr_stb,
	output logic      [DW_W-1:0]   dw_wr_data,
	output logic      [ADDR_W-1:0] dw_wr_addr,
	output logic                   dw_wr_fifo,
	input  wire logic [DW_W-1:0]   dw_rd_data,
	output logic                   dw_rd_done,
	output logic                   dw_rd_fifo
);

	// Synchronisers
	logic [PIN_N-1:0] pin_s1_r;
	logic [PIN_N-1:0] pin_s2_r;
	logic [AD_W-1:0]  ad_s1_r;
	logic [AD_W-1:0]  ad_s2_r;
	logic [1:0]       sync_ok_r;

	// Pin stages hold no real level until two edges after reset; mask them meanwhile
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_ok_r <= 2'h0;
		end else begin
			sync_ok_r <= {sync_ok_r[0], 1'b1};
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			ad_s1_r  <= '0;
			ad_s2_r  <= '0;
		end else begin
			pin_s1_r <= {cs_pin, rd_pin, wr_pin, latch_low_strobe, latch_high_strobe};
			pin_s2_r <= pin_s1_r;
			ad_s1_r  <= ad_in;
			ad_s2_r  <= ad_s1_r;
		end
	end

	// Polarity normalisation per pin
	logic [PIN_N-1:0] pol;
	logic [PIN_N-1:0] act;

	assign pol = {pol_cs, pol_rd, pol_wr, pol_latch_low, pol_latch_high};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_pol
			assign act[gi] = sync_ok_r[1] & (pin_s2_r[gi] == pol[gi]);
		end
	endgenerate

	// Cycle decode
	logic rd_cyc;
	logic wr_cyc;
	logic lo_act;
	logic hi_act;

	always_comb begin
		if (cfg_enable_dir) begin
			rd_cyc = act[PIN_CS] & act[PIN_WR] & act[PIN_RD];
			wr_cyc = act[PIN_CS] & act[PIN_WR] & ~act[PIN_RD];
		end else begin
			rd_cyc = act[PIN_CS] & act[PIN_RD];
			wr_cyc = act[PIN_CS] & act[PIN_WR];
		end
		lo_act = act[PIN_LO] & cfg_mux_mode;
		hi_act = act[PIN_HI] & cfg_mux_mode & cfg_dual_phase;
	end

	// Edge and qualification state
	logic [3:0] prev_r;
	logic [3:0] prev_nxt;
	logic       cs_lo_r;
	logic       cs_lo_nxt;
	logic       cs_hi_r;
	logic       cs_hi_nxt;
	logic       lo_end;
	logic       hi_end;
	logic       rd_start;
	logic       rd_end;
	logic       wr_end;
	logic       lo_take;
	logic       hi_take;

	always_comb begin
		prev_nxt  = {rd_cyc, wr_cyc, lo_act, hi_act};
		lo_end    = prev_r[1] & ~lo_act;
		hi_end    = prev_r[0] & ~hi_act;
		wr_end    = prev_r[2] & ~wr_cyc;
		rd_start  = rd_cyc & ~prev_r[3];
		rd_end    = prev_r[3] & ~rd_cyc;
		cs_lo_nxt = lo_act ? (cs_lo_r | act[PIN_CS]) : 1'b0;
		cs_hi_nxt = hi_act ? (cs_hi_r | act[PIN_CS]) : 1'b0;
		lo_take   = lo_end & (~cfg_cs_qualify | cs_lo_r);
		hi_take   = hi_end & (~cfg_cs_qualify | cs_hi_r);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_r  <= '0;
			cs_lo_r <= 1'b0;
			cs_hi_r <= 1'b0;
		end else begin
			prev_r  <= prev_nxt;
			cs_lo_r <= cs_lo_nxt;
			cs_hi_r <= cs_hi_nxt;
		end
	end

	// Address latch, kept as a byte address
	logic [ADDR_W-1:0] addr_r;
	logic [ADDR_W-1:0] addr_nxt;
	logic              end_r;
	logic              end_nxt;
	logic              fifo_r;
	logic              fifo_nxt;

	always_comb begin
		addr_nxt = addr_r;
		end_nxt  = end_r;
		fifo_nxt = fifo_r;
		if (lo_take) begin
			if (cfg_dual_phase) begin
				if (cfg_width16)
					addr_nxt[8:1] = ad_s2_r[7:0];
				else
					addr_nxt[7:0] = ad_s2_r[7:0];
			end else if (cfg_width16) begin
				addr_nxt = {ad_s2_r[SP16_TOP:0], 1'b0};
				end_nxt  = ad_s2_r[SP16_END];
				fifo_nxt = ad_s2_r[SP16_FIFO];
			end else begin
				addr_nxt = ad_s2_r[SP8_TOP:0];
				end_nxt  = ad_s2_r[SP8_END];
				fifo_nxt = ad_s2_r[SP8_FIFO];
			end
		end
		if (hi_take) begin
			if (cfg_width16) begin
				addr_nxt[9] = ad_s2_r[0];
				addr_nxt[0] = 1'b0;
				end_nxt     = ad_s2_r[DP16_END];
				fifo_nxt    = ad_s2_r[DP16_FIFO];
			end else begin
				addr_nxt[9:8] = ad_s2_r[1:0];
				end_nxt       = ad_s2_r[DP8_END];
				fifo_nxt      = ad_s2_r[DP8_FIFO];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			addr_r <= ADDR_RST;
			end_r  <= 1'b0;
			fifo_r <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			end_r  <= end_nxt;
			fifo_r <= fifo_nxt;
		end
	end

	// Effective address, byte order and FIFO select
	logic [ADDR_W-1:0] eff_addr;
	logic              eff_big;
	logic              eff_fifo;
	logic [1:0]        lane;
	logic [2:0]        pieces;

	always_comb begin
		eff_addr = cfg_mux_mode ? addr_r : index_addr;
		eff_big  = cfg_mux_mode ? end_r : cfg_endian_big;
		eff_fifo = cfg_mux_mode & fifo_r;
		pieces   = cfg_width16 ? PIECES_16 : PIECES_8;
		if (cfg_width16)
			lane = {eff_addr[1] ^ eff_big, 1'b0};
		else
			lane = eff_addr[1:0] ^ {eff_big, eff_big};
	end

	// Write assembly
	logic [DW_W-1:0]   asm_r;
	logic [DW_W-1:0]   asm_nxt;
	logic [2:0]        wcnt_r;
	logic [2:0]        wcnt_nxt;
	logic              wr_stb_r;
	logic              wr_stb_nxt;
	logic [DW_W-1:0]   wr_data_r;
	logic [DW_W-1:0]   wr_data_nxt;
	logic [ADDR_W-1:0] wr_addr_r;
	logic [ADDR_W-1:0] wr_addr_nxt;
	logic              wr_fifo_r;
	logic              wr_fifo_nxt;

	always_comb begin
		asm_nxt     = asm_r;
		wcnt_nxt    = wcnt_r;
		wr_stb_nxt  = 1'b0;
		wr_data_nxt = wr_data_r;
		wr_addr_nxt = wr_addr_r;
		wr_fifo_nxt = wr_fifo_r;
		if (wr_end) begin
			if (cfg_width16)
				asm_nxt[{lane, 3'b000} +: 16] = eff_big ?
					{ad_s2_r[7:0], ad_s2_r[15:8]} : ad_s2_r;
			else
				asm_nxt[{lane, 3'b000} +: 8] = ad_s2_r[7:0];
			if (wcnt_r + 3'h1 == pieces) begin
				wcnt_nxt    = 3'h0;
				wr_stb_nxt  = 1'b1;
				wr_data_nxt = asm_nxt;
				wr_addr_nxt = {eff_addr[9:2], 2'b00};
				wr_fifo_nxt = eff_fifo;
			end else begin
				wcnt_nxt = wcnt_r + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			asm_r     <= DW_RST;
			wcnt_r    <= 3'h0;
			wr_stb_r  <= 1'b0;
			wr_data_r <= DW_RST;
			wr_addr_r <= ADDR_RST;
			wr_fifo_r <= 1'b0;
		end else begin
			asm_r     <= asm_nxt;
			wcnt_r    <= wcnt_nxt;
			wr_stb_r  <= wr_stb_nxt;
			wr_data_r <= wr_data_nxt;
			wr_addr_r <= wr_addr_nxt;
			wr_fifo_r <= wr_fifo_nxt;
		end
	end

	// Read path: hold data at read start, drive selected lanes, count pieces
	logic [DW_W-1:0] hold_r;
	logic [DW_W-1:0] hold_nxt;
	logic [DW_W-1:0] rd_src;
	logic [2:0]      rcnt_r;
	logic [2:0]      rcnt_nxt;
	logic            rd_done_r;
	logic            rd_done_nxt;
	logic            rd_fifo_r;
	logic            rd_fifo_nxt;
	logic [AD_W-1:0] ad_out_r;
	logic [AD_W-1:0] ad_out_nxt;
	logic [AD_W-1:0] oe_n_r;
	logic [AD_W-1:0] oe_n_nxt;
	logic [15:0]     rd_word;

	always_comb begin
		hold_nxt    = rd_start ? dw_rd_data : hold_r;
		rd_src      = hold_nxt;
		rd_word     = rd_src[{lane, 3'b000} +: 16];
		rcnt_nxt    = rcnt_r;
		rd_done_nxt = 1'b0;
		rd_fifo_nxt = rd_fifo_r;
		ad_out_nxt  = ad_out_r;
		oe_n_nxt    = OE_OFF;
		if (rd_cyc) begin
			if (cfg_width16) begin
				ad_out_nxt = eff_big ? {rd_word[7:0], rd_word[15:8]} : rd_word;
				oe_n_nxt   = OE_ALL;
			end else begin
				ad_out_nxt = {8'h00, rd_word[7:0]};
				oe_n_nxt   = OE_LOW8;
			end
		end
		if (rd_end) begin
			if (rcnt_r + 3'h1 == pieces) begin
				rcnt_nxt    = 3'h0;
				rd_done_nxt = 1'b1;
				rd_fifo_nxt = eff_fifo;
			end else begin
				rcnt_nxt = rcnt_r + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_r    <= DW_RST;
			rcnt_r    <= 3'h0;
			rd_done_r <= 1'b0;
			rd_fifo_r <= 1'b0;
			ad_out_r  <= '0;
			oe_n_r    <= OE_OFF;
		end else begin
			hold_r    <= hold_nxt;
			rcnt_r    <= rcnt_nxt;
			rd_done_r <= rd_done_nxt;
			rd_fifo_r <= rd_fifo_nxt;
			ad_out_r  <= ad_out_nxt;
			oe_n_r    <= oe_n_nxt;
		end
	end

	// Registered copies of the effective address state
	logic [ADDR_W-1:0] haddr_r;
	logic              hbig_r;
	logic              hfifo_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			haddr_r <= ADDR_RST;
			hbig_r  <= 1'b0;
			hfifo_r <= 1'b0;
		end else begin
			haddr_r <= eff_addr;
			hbig_r  <= eff_big;
			hfifo_r <= eff_fifo;
		end
	end

	assign ad_out           = ad_out_r;
	assign ad_oe_n          = oe_n_r;
	assign host_addr        = haddr_r;
	assign host_big_endian  = hbig_r;
	assign host_fifo_direct = hfifo_r;
	assign dw_wr_stb        = wr_stb_r;
	assign dw_wr_data       = wr_data_r;
	assign dw_wr_addr       = wr_addr_r;
	assign dw_wr_fifo       = wr_fifo_r;
	assign dw_rd_done       = rd_done_r;
	assign dw_rd_fifo       = rd_fifo_r;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	addr_hold_a: assert property (!lo_take && !hi_take |=> $stable(addr_r))
		else $error("address changed without capture");

	sp8_capture_a: assert property (lo_take && !cfg_dual_phase && !cfg_width16 |=>
		addr_r == $past(ad_s2_r[9:0]) && end_r == $past(ad_s2_r[10])
		&& fifo_r == $past(ad_s2_r[11]))
		else $error("single phase byte capture wrong");

	sp16_capture_a: assert property (lo_take && !cfg_dual_phase && cfg_width16 |=>
		addr_r == {$past(ad_s2_r[8:0]), 1'b0} && end_r == $past(ad_s2_r[9]))
		else $error("single phase word capture wrong");

	cs_qualify_a: assert property (lo_end && !hi_end && cfg_cs_qualify && !cs_lo_r
		|=> $stable(addr_r) && $stable(end_r) && $stable(fifo_r))
		else $error("unqualified strobe captured");

	dp8_high_a: assert property (hi_take && !lo_take && !cfg_width16 |=>
		addr_r[9:8] == $past(ad_s2_r[1:0]) && end_r == $past(ad_s2_r[2])
		&& fifo_r == $past(ad_s2_r[3]) && addr_r[7:0] == $past(addr_r[7:0]))
		else $error("dual phase high capture wrong");

	upper_quiet_a: assert property (!$past(cfg_width16) |-> oe_n_r[15:8] == 8'hFF)
		else $error("upper pins driven in byte mode");

	wr_pieces_a: assert property (wr_end && wcnt_r == pieces - 3'h1
		|=> wr_stb_r && wcnt_r == 3'h0 ##1 !wr_stb_r)
		else $error("doubleword write not issued");

	rd_drive_a: assert property (rd_start |=> !oe_n_r[0] && hold_r == $past(dw_rd_data))
		else $error("read cycle not driven");

	byte_addr_a: assert property (cfg_mux_mode && cfg_width16 && lo_take ##1 1'b1
		|-> addr_r[0] == 1'b0)
		else $error("word address not converted");

	rd_single_c: cover property (rd_start ##[1:20] rd_end);
	wr_full_c: cover property (wr_stb_r && !cfg_width16);
	dual_both_c: cover property (lo_take ##[1:40] hi_take);
	fifo_wr_c: cover property (wr_stb_r && wr_fifo_r);

endmodule

// ==== hdl/hbl_pkg.sv ====
// Constants shared by the parallel host port address latch and data path
package hbl_pkg;

	// Widths
	localparam int AD_W   = 16;
	localparam int ADDR_W = 10;
	localparam int DW_W   = 32;

	// Positions in the synchronised control pin vector
	localparam int PIN_CS = 4;
	localparam int PIN_RD = 3;
	localparam int PIN_WR = 2;
	localparam int PIN_LO = 1;
	localparam int PIN_HI = 0;
	localparam int PIN_N  = 5;

	// Top address and select bit positions on the shared pins, single phase
	localparam int SP8_TOP   = 9;
	localparam int SP8_END   = 10;
	localparam int SP8_FIFO  = 11;
	localparam int SP16_TOP  = 8;
	localparam int SP16_END  = 9;
	localparam int SP16_FIFO = 10;

	// Select bit positions on the shared pins, high phase of dual phase
	localparam int DP8_END   = 2;
	localparam int DP8_FIFO  = 3;
	localparam int DP16_END  = 1;
	localparam int DP16_FIFO = 2;

	// Pieces per doubleword
	localparam logic [2:0] PIECES_8  = 3'h4;
	localparam logic [2:0] PIECES_16 = 3'h2;

	// Reset values and read output enable patterns
	localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
	localparam logic [DW_W-1:0]   DW_RST   = 32'h0000_0000;
	localparam logic [AD_W-1:0]   OE_OFF   = 16'hFFFF;
	localparam logic [AD_W-1:0]   OE_LOW8  = 16'hFF00;
	localparam logic [AD_W-1:0]   OE_ALL   = 16'h0000;

endpackage

// ==== dv/hbl_host_model.sv ====
// Host side model that drives the parallel host port pins
`timescale 1ns/1ps
module hbl_host_model (
	// Clock and mode
	input  wire logic        clk,
	input  wire logic        en_dir,
	input  wire logic [4:0]  pol,
	// Host pins
	output logic             cs_pin,
	output logic             rd_pin,
	output logic             wr_pin,
	output logic             latch_low_strobe,
	output logic             latch_high_strobe,
	output logic [15:0]      ad_in,
	input  wire logic [15:0] ad_out,
	input  wire logic [15:0] ad_oe_n
);
	logic [15:0] rd_q;
	logic [15:0] oe_q;

	initial begin
		ad_in = 16'h0000;
	end

	// All control pins to their inactive level
	task automatic idle();
		cs_pin <= ~pol[4];
		rd_pin <= ~pol[3];
		wr_pin <= ~pol[2];
		latch_low_strobe <= ~pol[1];
		latch_high_strobe <= ~pol[0];
	endtask

	// One cycle: 0 low latch, 1 high latch, 2 write, 3 read
	task automatic pulse(input int kind, input logic [15:0] v, input logic cs_on);
		@(posedge clk);
		if (kind != 3)
			ad_in <= v;
		else
			ad_in <= ~ad_in;
		cs_pin <= cs_on ? pol[4] : ~pol[4];
		case (kind)
			0: latch_low_strobe <= pol[1];
			1: latch_high_strobe <= pol[0];
			2: wr_pin <= pol[2];
			default: begin
				rd_pin <= pol[3];
				if (en_dir)
					wr_pin <= pol[2];
			end
		endcase
		// Active four clocks, data held six more
		repeat (4) @(posedge clk);
		rd_q = ad_out;
		oe_q = ad_oe_n;
		idle();
		repeat (6) @(posedge clk);
		// Released bus must not keep its last value
		ad_in <= ~ad_in;
	endtask
endmodule

// ==== dv/host_bus_mux_address_latch_test.sv ====
// Self-checking bench for the host port front end
`timescale 1ns/1ps
module host_bus_mux_address_latch_test;
	import hbl_pkg::*;
	logic              clk;
	logic              sys_rst;
	logic              cfg_mux_mode;
	logic              cfg_width16;
	logic              cfg_enable_dir;
	logic              cfg_dual_phase;
	logic              cfg_cs_qualify;
	logic              cfg_endian_big;
	logic [4:0]        pol;
	logic              cs_pin;
	logic              rd_pin;
	logic              wr_pin;
	logic              latch_low_strobe;
	logic              latch_high_strobe;
	logic [AD_W-1:0]   ad_in;
	logic [AD_W-1:0]   ad_out;
	logic [AD_W-1:0]   ad_oe_n;
	logic [ADDR_W-1:0] index_addr;
	logic [ADDR_W-1:0] host_addr;
	logic              host_big_endian;
	logic              host_fifo_direct;
	logic              dw_wr_stb;
	logic [DW_W-1:0]   dw_wr_data;
	logic [ADDR_W-1:0] dw_wr_addr;
	logic              dw_wr_fifo;
	logic [DW_W-1:0]   dw_rd_data;
	logic              dw_rd_done;
	logic              dw_rd_fifo;
	int                num_errors;
	int                comparisons;
	int                wr_cnt;
	int                rd_cnt;
	integer            seed;

	hbl_host_port u_hbl_host_port (
		.clk(clk), .sys_rst(sys_rst), .cfg_mux_mode(cfg_mux_mode), .cfg_width16(cfg_width16),
		.cfg_enable_dir(cfg_enable_dir), .cfg_dual_phase(cfg_dual_phase),
		.cfg_cs_qualify(cfg_cs_qualify), .cfg_endian_big(cfg_endian_big),
		.pol_cs(pol[PIN_CS]), .pol_rd(pol[PIN_RD]), .pol_wr(pol[PIN_WR]),
		.pol_latch_low(pol[PIN_LO]), .pol_latch_high(pol[PIN_HI]),
		.cs_pin(cs_pin), .rd_pin(rd_pin), .wr_pin(wr_pin), .latch_low_strobe(latch_low_strobe),
		.latch_high_strobe(latch_high_strobe), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
		.index_addr(index_addr), .host_addr(host_addr), .host_big_endian(host_big_endian),
		.host_fifo_direct(host_fifo_direct), .dw_wr_stb(dw_wr_stb), .dw_wr_data(dw_wr_data),
		.dw_wr_addr(dw_wr_addr), .dw_wr_fifo(dw_wr_fifo), .dw_rd_data(dw_rd_data),
		.dw_rd_done(dw_rd_done), .dw_rd_fifo(dw_rd_fifo));

	hbl_host_model u_hbl_host_model (
		.clk(clk), .en_dir(cfg_enable_dir), .pol(pol), .cs_pin(cs_pin), .rd_pin(rd_pin),
		.wr_pin(wr_pin), .latch_low_strobe(latch_low_strobe),
		.latch_high_strobe(latch_high_strobe), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Pulse counters for doubleword writes and reads
	always @(posedge clk) begin
		if (dw_wr_stb === 1'b1)
			wr_cnt <= wr_cnt + 1;
		if (dw_rd_done === 1'b1)
			rd_cnt <= rd_cnt + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Piece k of a doubleword as the host sees it
	function automatic logic [15:0] lane_val(input logic [31:0] dw, input int k, input logic e);
		if (cfg_width16)
			return e ? {dw[16*(k^1)+:8], dw[16*(k^1)+8+:8]} : dw[16*k+:16];
		return {8'h00, dw[8*(k^(e ? 3 : 0))+:8]};
	endfunction

	// New straps and polarities under reset
	task automatic set_cfg(input logic mux, input logic [31:0] r);
		@(posedge clk);
		sys_rst <= 1'b1;
		cfg_mux_mode <= mux;
		{cfg_width16, cfg_dual_phase, cfg_enable_dir, cfg_cs_qualify, cfg_endian_big} <= r[4:0];
		pol <= r[9:5];
		@(posedge clk);
		u_hbl_host_model.idle();
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic latch(input logic [9:0] a, input logic e, input logic f, input logic cs_on);
		logic [15:0] lo;
		logic [15:0] hi;
		lo = cfg_width16 ? {8'($random(seed)), a[8:1]} : {8'($random(seed)), a[7:0]};
		hi = cfg_width16 ? {13'h0000, f, e, a[9]} : {12'h000, f, e, a[9:8]};
		if (!cfg_dual_phase) begin
			u_hbl_host_model.pulse(0, cfg_width16 ? {5'h00, f, e, a[9:1]} : {4'h0, f, e, a}, cs_on);
		end else if ($random(seed) & 1) begin
			u_hbl_host_model.pulse(0, lo, cs_on);
			u_hbl_host_model.pulse(1, hi, cs_on);
		end else begin
			u_hbl_host_model.pulse(1, hi, cs_on);
			u_hbl_host_model.pulse(0, lo, cs_on);
		end
	endtask

	task automatic run_mux(input int it);
		logic [31:0] r;
		logic [9:0]  a;
		logic [9:0]  pa;
		logic        e;
		logic        f;
		logic [31:0] d;
		logic [15:0] sel;
		int          n;
		int          rot;
		int          k;
		r = $random(seed);
		if (it < 4)
			r[4:3] = 2'(it);
		set_cfg(1'b1, r);
		n = cfg_width16 ? 2 : 4;
		sel = cfg_width16 ? 16'hFFFF : 16'h00FF;
		a = (it < 2) ? 10'h3FC : 10'($random(seed) & 32'h3FC);
		e = $random(seed);
		f = $random(seed);
		latch(a, e, f, 1'b1);
		check(host_addr, a);
		check(host_big_endian, e);
		check(host_fifo_direct, f);
		latch(~a & 10'h3FC, ~e, ~f, 1'b0);
		check(host_addr, cfg_cs_qualify ? a : ~a & 10'h3FC);
		d = $random(seed);
		rot = {$random(seed)} % n;
		for (k = 0; k < n; k++) begin
			pa = a + 10'(((k + rot) % n) * (4 / n));
			latch(pa, e, f, 1'b1);
			u_hbl_host_model.pulse(2, lane_val(d, (k + rot) % n, e), 1'b1);
		end
		check(wr_cnt, it + 1);
		check(dw_wr_data, d);
		check(dw_wr_addr, a);
		check(dw_wr_fifo, f);
		dw_rd_data <= ~d;
		for (k = 0; k < n; k++) begin
			pa = a + 10'(((k + rot) % n) * (4 / n));
			latch(pa, e, f, 1'b1);
			u_hbl_host_model.pulse(3, 16'h0000, 1'b1);
			check(u_hbl_host_model.rd_q & sel, lane_val(~d, (k + rot) % n, e));
			check(u_hbl_host_model.oe_q, cfg_width16 ? OE_ALL : OE_LOW8);
			check(ad_oe_n, OE_OFF);
		end
		check(rd_cnt, it + 1);
		check(dw_rd_fifo, f);
		check(host_addr, pa);
		$display("Test %0d done, width16 %0d dual %0d", it, cfg_width16, cfg_dual_phase);
	endtask

	initial begin
		seed = 32'h6328;
		num_errors = 0;
		comparisons = 0;
		wr_cnt = 0;
		rd_cnt = 0;
		sys_rst = 1'b1;
		{cfg_mux_mode, cfg_width16, cfg_enable_dir, cfg_dual_phase} = 4'h8;
		{cfg_cs_qualify, cfg_endian_big} = 2'h0;
		pol = 5'h00;
		index_addr = 10'h000;
		dw_rd_data = 32'h0000_0000;
		u_hbl_host_model.idle();
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		check(host_addr, ADDR_RST);
		check(ad_oe_n, OE_OFF);
		$display("Test reset done");
		for (int it = 0; it < 30; it++)
			run_mux(it);
		set_cfg(1'b0, $random(seed));
		index_addr <= $random(seed);
		latch(10'h155, 1'b1, 1'b1, 1'b1);
		check(host_addr, index_addr);
		check(host_big_endian, cfg_endian_big);
		check(host_fifo_direct, 1'b0);
		$display("Test separate address done");
		close_out();
	end
endmodule
